// >>> tb/pll_ctrl_properties.sv
// Checker for the loop control block ports
`timescale 1ns/1ps
`default_nettype none
module pll_ctrl_checker import pll_ctrl_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Configuration port
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Status
  input wire logic reference_source_selector,
  input wire logic primary_clock_out,
  input wire logic lock
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic take;
  int quiet_reg;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Cycles since reset or the last write
  always_ff @(posedge sys_clk)
    if (srst || (take && wb_we_i)) quiet_reg <= 0;
    else if (quiet_reg < 1000) quiet_reg <= quiet_reg + 1;
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_after_take: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 8'h00)
    else $error("read data outside ack");
  a_write_drops_lock: assert property (take && wb_we_i |-> ##2 !lock)
    else $error("lock kept after write");
  a_switch_drops_lock: assert property ($changed(reference_source_selector) |-> ##[1:3] !lock)
    else $error("lock kept after source switch");
  a_lock_after_quiet: assert property ($rose(lock) |-> quiet_reg >= 100)
    else $error("lock rose too early");
  a_status_source: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == ADDR_STATUS)
    |-> wb_dat_o[7:1] == {6'h00, $past(reference_source_selector)})
    else $error("status source bit wrong");
  a_reset_clears: assert property (disable iff (1'b0)
    srst |=> !lock && !wb_ack_o && !primary_clock_out)
    else $error("outputs not cleared by reset");
endmodule // pll_ctrl_checker
bind pll_dynamic_control pll_ctrl_checker pll_ctrl_checker_inst (.sys_clk, .srst,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .reference_source_selector, .primary_clock_out, .lock);
`default_nettype wire

// >>> tb/pll_dynamic_control_tb.sv
// Self-checking bench for the loop control block
`timescale 1ns/1ps
`default_nettype none
module pll_dynamic_control_tb import pll_ctrl_pkg::*; ();
  logic sys_clk = 1'b0, srst = 1'b1, sel = 1'b0, pdir = 1'b0, ptog = 1'b0, run = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [1:0] psel = 2'h0;
  logic [3:0] adr = 4'h0;
  logic [7:0] wdat = 8'h00, d;
  wire [3:0] outs, route;
  wire [7:0] rdat;
  wire ack, lock, ref_pin, ref_route, fb_pin;
  int n_errors = 0, n_tests = 0, t, k;
  always #50 sys_clk = ~sys_clk;
  ref_clock_source ref_clock_source_inst (.run(run), .ref_pin(ref_pin),
    .ref_route(ref_route), .fb_pin(fb_pin));
  pll_dynamic_control pll_dynamic_control_inst (.sys_clk(sys_clk), .srst(srst),
    .reference_clock_in_pin(ref_pin), .reference_clock_in_route(ref_route),
    .feedback_clock_in_pin(fb_pin), .reference_source_selector(sel),
    .phase_output_select(psel), .phase_direction(pdir), .phase_step_toggle(ptog),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .primary_clock_out(outs[0]),
    .secondary_clock_out_a(outs[1]), .secondary_clock_out_b(outs[2]),
    .secondary_clock_out_c(outs[3]), .clock_route_out(route), .lock(lock));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One configuration port cycle, read data left in d
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] wd);
    @(negedge sys_clk);
    cyc = 1'b1;
    stb = 1'b1;
    we = w;
    adr = a;
    wdat = wd;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 8);
    d = rdat;
    chk("wb_ack", ack, 1'b1);
    @(negedge sys_clk);
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
  endtask
  // Cycles until the next rising edge of an output
  task automatic wrise(input int i);
    logic p;
    t = 0;
    do begin
      p = outs[i];
      @(negedge sys_clk);
      t++;
    end while (!(p === 1'b0 && outs[i] === 1'b1) && t < 6000);
  endtask
  task automatic wlock;
    k = 0;
    while (lock !== 1'b1 && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    chk("lock_up", lock, 1'b1);
  endtask
  task automatic step(input logic [1:0] s, input logic dr);
    @(negedge sys_clk);
    psel = s;
    pdir = dr;
    ptog = ~ptog;
    repeat (40) @(negedge sys_clk);
  endtask
  task automatic delta(input int exp);
    wrise(0);
    wrise(0);
    wrise(1);
    chk("phase_delta", 16'(t), 16'(exp));
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #4_000_000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    chk("lock_reset", lock, 1'b0);
    for (int a = 0; a < 16; a++) begin
      xfer(1'b0, 4'(a), 8'h00);
      chk("reset_value", d, a == 0 ? FB_INT_RST : 8'h00);
    end
    xfer(1'b1, ADDR_FB_INT, 8'h02);
    xfer(1'b1, ADDR_FRAC_HI, 8'h80);
    xfer(1'b1, ADDR_DIV0, 8'h04);
    xfer(1'b1, ADDR_ROUTE, 8'h05);
    xfer(1'b1, 4'hd, 8'h55);
    xfer(1'b0, 4'hd, 8'h00);
    chk("unmapped", d, 8'h00);
    xfer(1'b0, ADDR_FRAC_HI, 8'h00);
    chk("frac_hi", d, 8'h80);
    wlock;
    wrise(0);
    wrise(0);
    chk("frac_period", 16'(t), 16'd80);
    chk("route_mask", route, outs & 4'h5);
    xfer(1'b0, ADDR_STATUS, 8'h00);
    chk("status", d, 8'h01);
    @(negedge sys_clk);
    sel = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("lock_switch", lock, 1'b0);
    wlock;
    xfer(1'b0, ADDR_STATUS, 8'h00);
    chk("status_route", d, 8'h03);
    wrise(0);
    wrise(0);
    chk("route_period", 16'(t), 16'd80);
    xfer(1'b1, ADDR_FB_INT, 8'h01);
    xfer(1'b1, ADDR_FRAC_HI, 8'h00);
    xfer(1'b1, ADDR_DIV0, 8'h01);
    xfer(1'b1, ADDR_DIV0 + 4'h1, 8'h01);
    xfer(1'b1, ADDR_DIV3, 8'h7f);
    wrise(3);
    wrise(3);
    chk("div128_period", 16'(t), 16'd5120);
    wrise(2);
    wrise(2);
    chk("div2_period", 16'(t), 16'd40);
    delta(80);
    step(2'h1, 1'b1);
    delta(60);
    step(2'h1, 1'b0);
    delta(80);
    step(2'h1, 1'b0);
    delta(20);
    step(2'h0, 1'b1);
    delta(20);
    xfer(1'b1, ADDR_PHASE1, 8'h01);
    delta(60);
    step(2'h3, 1'b1);
    delta(60);
    xfer(1'b1, ADDR_CTRL, 8'h20);
    wlock;
    step(2'h2, 1'b1);
    chk("lock_fb_step", lock, 1'b0);
    xfer(1'b1, ADDR_CTRL, 8'h01);
    wrise(1);
    wrise(1);
    chk("cascade_period", 16'(t), 16'd160);
    xfer(1'b1, ADDR_CTRL, 8'h08);
    wlock;
    run = 1'b0;
    repeat (120) @(negedge sys_clk);
    chk("lock_idle", lock, 1'b0);
    tally_and_finish;
  end
endmodule // pll_dynamic_control_tb
`default_nettype wire

// >>> tb/ref_clock_source.sv
// Far-side model: reference and feedback clock sources
`timescale 1ns/1ps
`default_nettype none
module ref_clock_source (
  // Run control
  input wire logic run,
  // Clock pins
  output logic ref_pin,
  output logic ref_route,
  output logic fb_pin
);
  initial ref_pin = 1'b0;
  initial ref_route = 1'b0;
  // Pin reference, stands low while stopped
  always begin
    #1000;
    ref_pin = run ? ~ref_pin : 1'b0;
  end
  // Routed reference lags the pin source
  always @(ref_pin) ref_route <= #370 ref_pin;
  assign fb_pin = ref_pin;
endmodule // ref_clock_source
`default_nettype wire

// >>> verilog/out_divider.sv
// One output divider with preset, phase step and cascade tick
`timescale 1ns/1ps
`default_nettype none
module out_divider import pll_ctrl_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Input ticks and control
  input wire logic tick_in,
  input wire logic [6:0] div_code,
  input wire logic [6:0] preset,
  input wire div_ctl_t ctl,
  // Output level and toggle tick
  output logic level,
  output logic tick_out
);
  div_state_t s_reg;
  div_state_t s_next;
  logic step;

  always_comb begin
    s_next = s_reg;
    step = tick_in;
    s_next.tick = 1'b0;
    if (s_reg.ret_p && tick_in) begin
      step = 1'b0;
      s_next.ret_p = 1'b0;
    end else if (s_reg.adv_p && !tick_in) begin
      step = 1'b1;
      s_next.adv_p = 1'b0;
    end
    if (ctl.adv) begin
      s_next.adv_p = 1'b1;
    end
    if (ctl.ret) begin
      s_next.ret_p = 1'b1;
    end
    if (step) begin
      if (s_reg.cnt >= div_code) begin
        s_next.cnt = 7'h00;
        s_next.level = ~s_reg.level;
        s_next.tick = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 7'h01;
      end
    end
    if (ctl.load) begin
      s_next.cnt = preset;
      s_next.level = 1'b0;
      s_next.adv_p = 1'b0;
      s_next.ret_p = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level = s_reg.level;
  assign tick_out = s_reg.tick;
endmodule // out_divider
`default_nettype wire

// >>> verilog/pin_sync3.sv
// Three-stage synchroniser for the foreign clock and step pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 import pll_ctrl_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Pins
  input wire pin_bus_t pins,
  output pin_bus_t pins_q
);
  sync_state_t s_reg;
  sync_state_t s_next;
  logic [3:0] agree;

  always_comb begin
    s_next = s_reg;
    agree = ~(s_reg.s2 ^ s_reg.s3);
    s_next.s1 = pins;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.q = pin_bus_t'((s_reg.q & ~agree) | (s_reg.s3 & agree));
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins_q = s_reg.q;
endmodule // pin_sync3
`default_nettype wire

// >>> verilog/pll_ctrl_pkg.sv
// Package: constants and carrier types for the loop control block
package pll_ctrl_pkg;

  // Clock and timing
  localparam int SYS_CLK_PERIOD_NS = 100;
  localparam int RELOCK_TIME_NS = 10000;
  localparam int IDLE_TIMEOUT_NS = 10000;
  localparam logic [6:0] RELOCK_CYC =
    7'((RELOCK_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
  localparam logic [6:0] IDLE_TIMEOUT_CYC = 7'(IDLE_TIMEOUT_NS / SYS_CLK_PERIOD_NS);

  // Configuration port offsets
  localparam logic [3:0] ADDR_FB_INT = 4'h0;
  localparam logic [3:0] ADDR_FRAC_LO = 4'h1;
  localparam logic [3:0] ADDR_FRAC_HI = 4'h2;
  localparam logic [3:0] ADDR_DIV0 = 4'h3;
  localparam logic [3:0] ADDR_DIV1 = 4'h4;
  localparam logic [3:0] ADDR_DIV2 = 4'h5;
  localparam logic [3:0] ADDR_DIV3 = 4'h6;
  localparam logic [3:0] ADDR_CTRL = 4'h7;
  localparam logic [3:0] ADDR_ROUTE = 4'h8;
  localparam logic [3:0] ADDR_PHASE1 = 4'h9;
  localparam logic [3:0] ADDR_PHASE2 = 4'ha;
  localparam logic [3:0] ADDR_PHASE3 = 4'hb;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  // Control field positions
  localparam int CTRL_CASCADE_LSB = 0;
  localparam int CTRL_FB_PIN_BIT = 3;
  localparam int CTRL_FB_SEL_LSB = 4;

  // Reset values
  localparam logic [7:0] FB_INT_RST = 8'h01;
  localparam logic [15:0] FRAC_RST = 16'h0000;
  localparam logic [6:0] DIV_RST = 7'h00;
  localparam logic [6:0] PHASE_RST = 7'h00;
  localparam logic [3:0] ROUTE_RST = 4'h0;
  localparam logic [15:0] CREDIT_ONE = 16'hffff;

  // Pins that cross into the system clock domain
  typedef struct packed {
    logic ref_pin;
    logic ref_route;
    logic fb_pin;
    logic step;
  } pin_bus_t;

  typedef struct packed {
    pin_bus_t s1;
    pin_bus_t s2;
    pin_bus_t s3;
    pin_bus_t q;
  } sync_state_t;

  // Divider control and state
  typedef struct packed {
    logic load;
    logic adv;
    logic ret;
  } div_ctl_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic level;
    logic tick;
    logic adv_p;
    logic ret_p;
  } div_state_t;

  typedef struct packed {
    logic [7:0] fb_int;
    logic [15:0] frac;
    logic [3:0][6:0] div;
    logic [2:0] cascade;
    logic fb_pin;
    logic [1:0] fb_sel;
    logic [3:0] route_en;
    logic [2:0][6:0] phase;
  } cfg_t;

  typedef struct packed {
    cfg_t cfg;
    logic ack;
    logic [7:0] rdata;
    logic [25:0] credit;
    logic vco_tick;
    logic ref_prev;
    logic fb_prev;
    logic step_prev;
    logic src_prev;
    logic [6:0] ref_idle;
    logic [6:0] fb_idle;
    logic [6:0] relock;
    logic lock;
    logic load;
    logic [3:0] adv;
    logic [3:0] ret;
    logic [3:0] clk_out;
    logic [3:0] route_out;
  } top_state_t;

endpackage

// >>> verilog/pll_dynamic_control.sv
// Digital control of a fractional-N clock synthesis loop
// Functional notes
// - Fractional multiplication with 16-bit fraction.
// - Each output divider spans 1 to 128.
// - Output dividers can be chained in series.
// - Every output feeds network or routing.
// - Lock asserts on lock, drops on loss.
// - Secondary outputs take phase offset versus primary.
// - Phase offset static or dynamically adjusted.
// - Reference selectable between two sources dynamically.
// - Settings rewritable over WISHBONE; relock afterwards.
// - Each toggle moves selected secondary phase one step; select 0 is ignored.
// - Reference from pin or internal routing.
// - Feedback from routing or pin.
// - Feedback divider multiplies reference frequency.
`timescale 1ns/1ps
`default_nettype none
module pll_dynamic_control import pll_ctrl_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Reference and feedback clocks
  input wire logic reference_clock_in_pin,
  input wire logic reference_clock_in_route,
  input wire logic feedback_clock_in_pin,
  input wire logic reference_source_selector,
  // Dynamic phase control
  input wire logic [1:0] phase_output_select,
  input wire logic phase_direction,
  input wire logic phase_step_toggle,
  // WISHBONE configuration port
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  // Clock outputs and status
  output logic primary_clock_out,
  output logic secondary_clock_out_a,
  output logic secondary_clock_out_b,
  output logic secondary_clock_out_c,
  output logic [3:0] clock_route_out,
  output logic lock
);
  top_state_t s_reg;
  top_state_t s_next;
  pin_bus_t pins;
  pin_bus_t pins_q;
  logic [3:0] div_level;
  logic [3:0] div_tick;
  logic [3:0] src_tick;
  logic [3:0][6:0] preset;
  div_ctl_t [3:0] ctl;
  logic ref_edge;
  logic fb_edge;
  logic step_edge;
  logic wb_take;
  logic wb_write;
  logic disturb;
  logic [25:0] sum;

  // Foreign inputs
  assign pins.ref_pin = reference_clock_in_pin;
  assign pins.ref_route = reference_clock_in_route;
  assign pins.fb_pin = feedback_clock_in_pin;
  assign pins.step = phase_step_toggle;

  pin_sync3 pin_sync3_inst (
    .sys_clk(sys_clk),
    .srst(srst),
    .pins(pins),
    .pins_q(pins_q)
  );

  // Output dividers, optionally chained
  assign preset = {s_reg.cfg.phase, PHASE_RST};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_div
      if (gi == 0) begin : g_first
        assign src_tick[gi] = s_reg.vco_tick;
      end else begin : g_chain
        assign src_tick[gi] = s_reg.cfg.cascade[gi-1] ? div_tick[gi-1] : s_reg.vco_tick;
      end
      assign ctl[gi].load = s_reg.load;
      assign ctl[gi].adv = s_reg.adv[gi];
      assign ctl[gi].ret = s_reg.ret[gi];
      out_divider out_divider_inst (
        .sys_clk(sys_clk),
        .srst(srst),
        .tick_in(src_tick[gi]),
        .div_code(s_reg.cfg.div[gi]),
        .preset(preset[gi]),
        .ctl(ctl[gi]),
        .level(div_level[gi]),
        .tick_out(div_tick[gi])
      );
    end
  endgenerate

  always_comb begin
    s_next = s_reg;
    // Edge detection on synchronised inputs
    ref_edge = 1'b0;
    fb_edge = 1'b0;
    step_edge = 1'b0;
    disturb = 1'b0;
    s_next.ref_prev = reference_source_selector ? pins_q.ref_route : pins_q.ref_pin;
    ref_edge = s_next.ref_prev && !s_reg.ref_prev;
    s_next.fb_prev = s_reg.cfg.fb_pin ? pins_q.fb_pin : div_level[s_reg.cfg.fb_sel];
    fb_edge = s_next.fb_prev && !s_reg.fb_prev;
    s_next.step_prev = pins_q.step;
    step_edge = pins_q.step != s_reg.step_prev;

    // WISHBONE classic slave, one wait state
    wb_take = wb_cyc_i && wb_stb_i && !s_reg.ack;
    wb_write = wb_take && wb_we_i;
    s_next.ack = wb_take;
    s_next.rdata = 8'h00;
    s_next.load = 1'b0;
    if (wb_take) begin
      case (wb_adr_i)
        ADDR_FB_INT: begin
          s_next.rdata = s_reg.cfg.fb_int;
        end
        ADDR_FRAC_LO: begin
          s_next.rdata = s_reg.cfg.frac[7:0];
        end
        ADDR_FRAC_HI: begin
          s_next.rdata = s_reg.cfg.frac[15:8];
        end
        ADDR_DIV0: begin
          s_next.rdata = {1'b0, s_reg.cfg.div[0]};
        end
        ADDR_DIV1: begin
          s_next.rdata = {1'b0, s_reg.cfg.div[1]};
        end
        ADDR_DIV2: begin
          s_next.rdata = {1'b0, s_reg.cfg.div[2]};
        end
        ADDR_DIV3: begin
          s_next.rdata = {1'b0, s_reg.cfg.div[3]};
        end
        ADDR_CTRL: begin
          s_next.rdata = {2'b00, s_reg.cfg.fb_sel, s_reg.cfg.fb_pin, s_reg.cfg.cascade};
        end
        ADDR_ROUTE: begin
          s_next.rdata = {4'h0, s_reg.cfg.route_en};
        end
        ADDR_PHASE1: begin
          s_next.rdata = {1'b0, s_reg.cfg.phase[0]};
        end
        ADDR_PHASE2: begin
          s_next.rdata = {1'b0, s_reg.cfg.phase[1]};
        end
        ADDR_PHASE3: begin
          s_next.rdata = {1'b0, s_reg.cfg.phase[2]};
        end
        ADDR_STATUS: begin
          s_next.rdata = {6'h00, reference_source_selector, s_reg.lock};
        end
        default: begin
          s_next.rdata = 8'h00;
        end
      endcase
    end
    if (wb_write) begin
      s_next.load = 1'b1;
      disturb = 1'b1;
      case (wb_adr_i)
        ADDR_FB_INT: begin
          s_next.cfg.fb_int = wb_dat_i;
        end
        ADDR_FRAC_LO: begin
          s_next.cfg.frac[7:0] = wb_dat_i;
        end
        ADDR_FRAC_HI: begin
          s_next.cfg.frac[15:8] = wb_dat_i;
        end
        ADDR_DIV0: begin
          s_next.cfg.div[0] = wb_dat_i[6:0];
        end
        ADDR_DIV1: begin
          s_next.cfg.div[1] = wb_dat_i[6:0];
        end
        ADDR_DIV2: begin
          s_next.cfg.div[2] = wb_dat_i[6:0];
        end
        ADDR_DIV3: begin
          s_next.cfg.div[3] = wb_dat_i[6:0];
        end
        ADDR_CTRL: begin
          s_next.cfg.cascade = wb_dat_i[CTRL_CASCADE_LSB +: 3];
          s_next.cfg.fb_pin = wb_dat_i[CTRL_FB_PIN_BIT];
          s_next.cfg.fb_sel = wb_dat_i[CTRL_FB_SEL_LSB +: 2];
        end
        ADDR_ROUTE: begin
          s_next.cfg.route_en = wb_dat_i[3:0];
        end
        ADDR_PHASE1: begin
          s_next.cfg.phase[0] = wb_dat_i[6:0];
        end
        ADDR_PHASE2: begin
          s_next.cfg.phase[1] = wb_dat_i[6:0];
        end
        ADDR_PHASE3: begin
          s_next.cfg.phase[2] = wb_dat_i[6:0];
        end
        default: begin
          s_next.cfg = s_reg.cfg;
        end
      endcase
    end

    // Fractional-N tick generator
    sum = s_reg.credit;
    if (ref_edge && !s_reg.credit[25]) begin
      sum = s_reg.credit + {2'b00, s_reg.cfg.fb_int, s_reg.cfg.frac};
    end
    s_next.vco_tick = 1'b0;
    if (sum > {10'h000, CREDIT_ONE}) begin
      s_next.vco_tick = 1'b1;
      sum = sum - {10'h001, 16'h0000};
    end
    s_next.credit = sum;

    // Dynamic phase stepping of secondary outputs
    s_next.adv = 4'h0;
    s_next.ret = 4'h0;
    if (step_edge && phase_output_select != 2'b00) begin
      if (phase_direction) begin
        s_next.adv[phase_output_select] = 1'b1;
      end else begin
        s_next.ret[phase_output_select] = 1'b1;
      end
      if (!s_reg.cfg.fb_pin && phase_output_select == s_reg.cfg.fb_sel) begin
        disturb = 1'b1;
      end
    end

    // Reference and feedback activity watch
    s_next.src_prev = reference_source_selector;
    if (s_reg.src_prev != reference_source_selector) begin
      disturb = 1'b1;
    end
    if (ref_edge) begin
      s_next.ref_idle = 7'h00;
    end else if (s_reg.ref_idle != IDLE_TIMEOUT_CYC) begin
      s_next.ref_idle = s_reg.ref_idle + 7'h01;
    end
    if (fb_edge) begin
      s_next.fb_idle = 7'h00;
    end else if (s_reg.fb_idle != IDLE_TIMEOUT_CYC) begin
      s_next.fb_idle = s_reg.fb_idle + 7'h01;
    end
    if (s_reg.ref_idle == IDLE_TIMEOUT_CYC || s_reg.fb_idle == IDLE_TIMEOUT_CYC) begin
      disturb = 1'b1;
    end

    // Lock indicator
    if (disturb) begin
      s_next.lock = 1'b0;
      s_next.relock = RELOCK_CYC;
    end else if (s_reg.relock != 7'h00) begin
      s_next.relock = s_reg.relock - 7'h01;
    end else begin
      s_next.lock = 1'b1;
    end

    // Registered clock outputs
    s_next.clk_out = div_level;
    s_next.route_out = div_level & s_reg.cfg.route_en;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.cfg.fb_int <= FB_INT_RST;
      s_reg.cfg.frac <= FRAC_RST;
      s_reg.cfg.div <= {4{DIV_RST}};
      s_reg.cfg.phase <= {3{PHASE_RST}};
      s_reg.cfg.route_en <= ROUTE_RST;
      s_reg.relock <= RELOCK_CYC;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign wb_dat_o = s_reg.rdata;
  assign wb_ack_o = s_reg.ack;
  assign primary_clock_out = s_reg.clk_out[0];
  assign secondary_clock_out_a = s_reg.clk_out[1];
  assign secondary_clock_out_b = s_reg.clk_out[2];
  assign secondary_clock_out_c = s_reg.clk_out[3];
  assign clock_route_out = s_reg.route_out;
  assign lock = s_reg.lock;
endmodule // pll_dynamic_control
`default_nettype wire
